// ===== rtl/spi_channel.sv
// Serial peripheral channel with register file, master and slave modes
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module spi_channel
  import spi_channel_pkg::*;
(
  // Clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // Register port
  input  wire logic [spi_channel_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [spi_channel_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                           wr_i,
  input  wire logic                           rd_i,
  output logic      [spi_channel_pkg::DATA_W-1:0] rdata_o,
  // Timer channel clock, sampled
  input  wire logic                           timer_clk_i,
  // Serial pins
  input  wire logic                           serial_clock_pin_i,
  output logic                                serial_clock_pin_o,
  output logic                                serial_clock_pin_oe_n_o,
  input  wire logic                           slave_select_n_i,
  input  wire logic                           serial_data_in_i,
  output logic                                serial_data_out_o,
  // Shared interrupt request
  output logic                                irq_o
);
  import spi_channel_pkg::*;

  typedef enum logic [1:0]
  {
    M_IDLE  = 2'b00,
    M_SHIFT = 2'b01,
    M_DONE  = 2'b10
  } mstate_t;

  logic [15:0] control_r;
  logic [7:0]  tx_buf_r;
  logic [7:0]  rx_buf_r;
  logic [7:0]  shift_r;
  logic        tx_empty_r;
  logic        rx_full_r;
  logic        busy_r;
  logic        loaded_r;
  logic [2:0]  bit_cnt_r;
  logic        sclk_r;
  logic        sclk_in_r;
  logic        timer_r;
  logic [1:0]  div_r;
  mstate_t     mstate_r;
  logic        phase_r;

  logic        enable;
  logic        master;
  logic        clock_polarity_select;
  logic        clock_phase_select;
  logic        lsb_first;
  logic        wr_tx;
  logic        rd_rx;
  logic        tick;
  logic        lead_edge;
  logic        trail_edge;
  logic        load_now;
  logic        byte_done;
  logic        sample_bit;
  logic        launch_bit;
  logic [7:0]  shifted;

  assign enable    = control_r[CT_ENABLE];
  assign master    = control_r[CT_MASTER];
  assign clock_polarity_select      = control_r[CT_CLOCK_POLARITY_SELECT];
  assign clock_phase_select      = control_r[CT_CLOCK_PHASE_SELECT];
  assign lsb_first = control_r[CT_LSB_FIRST];
  assign wr_tx     = wr_i && (addr_i == OFS_TX_BYTE);
  assign rd_rx     = rd_i && (addr_i == OFS_RX_BYTE);

  // Master shift tick: every second system clock or rising edge of the timer output
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_r   <= 2'h0;
      timer_r <= 1'b0;
    end
    else
    begin
      timer_r <= timer_clk_i;
      if (div_r == HALF_DIV_LAST)
        div_r <= 2'h0;
      else
        div_r <= div_r + 2'h1;
    end
  end

  always_comb
  begin
    if (control_r[CT_CLK_TIMER])
      tick = timer_clk_i && !timer_r;
    else
      tick = (div_r == HALF_DIV_LAST);
  end

  // Edge detection on the serial clock seen in slave mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sclk_in_r <= 1'b0;
    else
      sclk_in_r <= serial_clock_pin_i ^ clock_polarity_select;
  end

  // Leading edge leaves idle level, trailing edge returns to it
  always_comb
  begin
    lead_edge  = 1'b0;
    trail_edge = 1'b0;
    if (enable && master && mstate_r == M_SHIFT && tick)
    begin
      lead_edge  = !phase_r;
      trail_edge = phase_r;
    end
    else if (enable && !master && !slave_select_n_i)
    begin
      lead_edge  = (serial_clock_pin_i ^ clock_polarity_select) && !sclk_in_r;
      trail_edge = !(serial_clock_pin_i ^ clock_polarity_select) && sclk_in_r;
    end
  end

  // Phase 0 samples on the leading edge, phase 1 launches on it
  assign sample_bit = clock_phase_select ? trail_edge : lead_edge;
  assign launch_bit = clock_phase_select ? lead_edge : trail_edge;

  // Next shifter contents after taking one input bit
  assign shifted = lsb_first ? {serial_data_in_i, shift_r[7:1]}
                             : {shift_r[6:0], serial_data_in_i};

  // Buffered byte enters shifter: master on idle start, slave when selected
  always_comb
  begin
    load_now = 1'b0;
    if (enable && !tx_empty_r)
    begin
      if (master)
        load_now = (mstate_r == M_IDLE);
      else
        load_now = !loaded_r && !slave_select_n_i;
    end
  end

  assign byte_done = sample_bit && (bit_cnt_r == BITS_LAST);

  // Master sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable)
    begin
      mstate_r <= M_IDLE;
      phase_r  <= 1'b0;
    end
    else
    begin
      unique case (mstate_r)
        M_IDLE:
        begin
          phase_r <= 1'b0;
          if (master && load_now)
            mstate_r <= M_SHIFT;
        end
        M_SHIFT:
        begin
          if (tick)
          begin
            phase_r <= !phase_r;
            // Phase 1 samples on the trailing edge, so the last sample ends the frame
            if (phase_r && (clock_phase_select ? byte_done : (bit_cnt_r == 3'h0 && !loaded_r)))
              mstate_r <= M_DONE;
          end
        end
        M_DONE:
          mstate_r <= M_IDLE;
        default:
          mstate_r <= M_IDLE;
      endcase
    end
  end

  // Shifter, bit counter and loaded marker
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable)
    begin
      shift_r   <= 8'h00;
      bit_cnt_r <= 3'h0;
      loaded_r  <= 1'b0;
    end
    else if (load_now)
    begin
      shift_r   <= tx_buf_r;
      bit_cnt_r <= 3'h0;
      loaded_r  <= 1'b1;
    end
    else
    begin
      if (sample_bit)
      begin
        shift_r   <= shifted;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (byte_done)
          loaded_r <= 1'b0;
      end
      if (!master && slave_select_n_i)
      begin
        bit_cnt_r <= 3'h0;
        loaded_r  <= 1'b0;
      end
    end
  end

  // Serial data out follows the bit at the shifter's outgoing end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      serial_data_out_o <= 1'b0;
    else if (load_now)
      serial_data_out_o <= lsb_first ? tx_buf_r[0] : tx_buf_r[7];
    else if (launch_bit && bit_cnt_r != 3'h0)
      serial_data_out_o <= lsb_first ? shift_r[0] : shift_r[7];
  end

  // Serial clock drive: idle at polarity level, toggle each master tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_r                  <= 1'b0;
      serial_clock_pin_o      <= 1'b0;
      serial_clock_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      if (enable && master && mstate_r == M_SHIFT && tick)
        sclk_r <= !sclk_r;
      else if (mstate_r != M_SHIFT)
        sclk_r <= 1'b0;
      serial_clock_pin_o      <= sclk_r ^ clock_polarity_select;
      serial_clock_pin_oe_n_o <= !(enable && master);
    end
  end

  // Transmit buffer and its empty flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_buf_r   <= TX_BYTE_RESET;
      tx_empty_r <= 1'b1;
    end
    else
    begin
      if (wr_tx)
        tx_buf_r <= wdata_i[7:0];
      if (load_now)
        tx_empty_r <= 1'b1;
      else if (wr_tx)
        tx_empty_r <= 1'b0;
    end
  end

  // Receive buffer and full flag; completion wins over a same-cycle read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_buf_r  <= RX_BYTE_RESET;
      rx_full_r <= 1'b0;
    end
    else if (byte_done && !load_now)
    begin
      rx_buf_r  <= shifted;
      rx_full_r <= 1'b1;
    end
    else if (rd_rx)
      rx_full_r <= 1'b0;
  end

  // Busy: transfer in progress (master) or select low (slave)
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_r <= 1'b0;
    else if (master)
      busy_r <= enable && (load_now || (mstate_r == M_SHIFT));
    else
      busy_r <= !slave_select_n_i;
  end

  // Shared interrupt request, one cycle per event
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= (load_now && control_r[CT_TX_IRQ_EN])
             || (byte_done && !load_now && control_r[CT_RX_IRQ_EN]);
  end

  // Control register write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      control_r <= CONTROL_RESET;
    else if (wr_i && addr_i == OFS_CONTROL)
      control_r <= wdata_i & CONTROL_MASK;
  end

  // Read data, one cycle after the read strobe; zero otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      unique case (addr_i)
        OFS_STATUS:  rdata_o <= {13'h0000, busy_r, rx_full_r, tx_empty_r};
        OFS_TX_BYTE: rdata_o <= {8'h00, tx_buf_r};
        OFS_RX_BYTE: rdata_o <= {8'h00, rx_buf_r};
        OFS_CONTROL: rdata_o <= control_r;
        default:     rdata_o <= 16'h0000;
      endcase
    end
    else
      rdata_o <= 16'h0000;
  end

endmodule
`default_nettype wire

// ===== rtl/spi_channel_pkg.sv
// Register map, field positions and reset values of the serial channel
package spi_channel_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam logic [15:0] OFS_STATUS      = 16'h4320;
  localparam logic [15:0] OFS_TX_BYTE     = 16'h4322;
  localparam logic [15:0] OFS_RX_BYTE     = 16'h4324;
  localparam logic [15:0] OFS_CONTROL     = 16'h4326;
  // Status bits
  localparam int          ST_TX_EMPTY     = 0;
  localparam int          ST_RX_FULL      = 1;
  localparam int          ST_BUSY         = 2;
  // Control bits
  localparam int          CT_ENABLE       = 0;
  localparam int          CT_MASTER       = 1;
  localparam int          CT_CLOCK_POLARITY_SELECT         = 2;
  localparam int          CT_CLOCK_PHASE_SELECT         = 3;
  localparam int          CT_TX_IRQ_EN    = 4;
  localparam int          CT_RX_IRQ_EN    = 5;
  localparam int          CT_LSB_FIRST    = 8;
  localparam int          CT_CLK_TIMER    = 9;
  localparam logic [15:0] CONTROL_MASK    = 16'h033f;
  localparam logic [15:0] CONTROL_RESET   = 16'h0000;
  localparam logic [7:0]  TX_BYTE_RESET   = 8'h00;
  localparam logic [7:0]  RX_BYTE_RESET   = 8'h00;
  // System clock divided by four: toggle the serial clock every two cycles
  localparam int          PCLK_DIV        = 4;
  localparam logic [1:0]  HALF_DIV_LAST   = 2'((PCLK_DIV / 2) - 1);
  localparam logic [3:0]  EDGES_PER_BYTE  = 4'h0;
  localparam logic [2:0]  BITS_LAST       = 3'h7;
endpackage

// ===== test/spi_channel_sva.sv
// Port checker for the serial channel
`timescale 1ns/1ns
`default_nettype none
module spi_channel_sva
  import spi_channel_pkg::*;
(
  // Clock and register port
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  // Pins
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe_n_o,
  input wire logic        irq_o
);
  logic [15:0] ctl_r;
  logic        run;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctl_r <= 16'h0000;
    else if (wr_i && addr_i == OFS_CONTROL)
      ctl_r <= wdata_i & CONTROL_MASK;
  end
  assign run = ctl_r[CT_ENABLE] & ctl_r[CT_MASTER] & !ctl_r[CT_CLK_TIMER];
  sequence s_rd(logic [15:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence s_tx_go;
    wr_i && addr_i == OFS_TX_BYTE && run;
  endsequence
  a_idle_rdata: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero");
  a_ctl_back: assert property (s_rd(OFS_CONTROL) |=> rdata_o == $past(ctl_r))
    else $error("control readback");
  a_status_rsvd: assert property (s_rd(OFS_STATUS) |=> rdata_o[15:3] == 13'h0000)
    else $error("status reserved bits");
  a_rx_rsvd: assert property (s_rd(OFS_RX_BYTE) |=> rdata_o[15:8] == 8'h00)
    else $error("receive reserved bits");
  a_tx_starts: assert property (s_tx_go |-> ##[1:40] serial_clock_pin_o != ctl_r[CT_CLOCK_POLARITY_SELECT])
    else $error("no serial clock");
  a_sclk_div: assert property (run && $changed(serial_clock_pin_o) |=> $stable(serial_clock_pin_o))
    else $error("clock half period");
  a_oe_slave: assert property (!ctl_r[CT_MASTER] ##1 !ctl_r[CT_MASTER] |-> serial_clock_pin_oe_n_o)
    else $error("clock driven in slave");
  a_irq_masked: assert property (ctl_r[5:4] == 2'b00 [*3] |-> !irq_o)
    else $error("masked request");
endmodule
bind spi_channel spi_channel_sva spi_channel_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe_n_o(serial_clock_pin_oe_n_o), .irq_o(irq_o));
`default_nettype wire

// ===== test/spi_peer.sv
// Far-side device: slave on our clock, or master driving select and clock
`timescale 1ns/1ns
`default_nettype none
module spi_peer
(
  // Clock and role
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       lead_i,
  input  wire logic       go_i,
  input  wire logic [7:0] tx_i,
  // Wire side
  input  wire logic       sclk_i,
  input  wire logic       sdo_i,
  output logic            sclk_o,
  output logic            ss_n_o,
  output logic            sdi_o,
  output logic [7:0]      rx_o
);
  logic       prev_r;
  logic       cap_r;
  logic [2:0] div_r;
  logic [4:0] cnt_r;
  logic       sc;
  assign sc = lead_i ? sclk_o : sclk_i;
  assign sdi_o = rx_o[7];
  // Mode 0: sample on rise, launch on fall, MSB first on the wire
  // Seen on the falling system clock so a new bit settles before the channel samples
  always_ff @(negedge clk_i)
  begin
    prev_r <= rst_i ? 1'b0 : sc;
    if (go_i)
      rx_o <= tx_i;
    else if (sc && !prev_r)
      cap_r <= sdo_i;
    else if (!sc && prev_r)
      rx_o <= {rx_o[6:0], cap_r};
  end
  // Master role: 16 half periods of 8 cycles, clock parked low between frames
  always_ff @(posedge clk_i)
  begin
    div_r <= div_r + 3'h1;
    if (rst_i)
    begin
      ss_n_o <= 1'b1;
      sclk_o <= 1'b0;
    end
    else if (go_i && lead_i)
    begin
      ss_n_o <= 1'b0;
      cnt_r <= 5'h00;
      div_r <= 3'h0;
    end
    else if (!ss_n_o && div_r == 3'h7)
    begin
      ss_n_o <= cnt_r == 5'h10;
      sclk_o <= cnt_r == 5'h10 ? 1'b0 : ~sclk_o;
      cnt_r <= cnt_r + 5'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test/spi_channel_tb_top.sv
// Self-checking bench for the serial channel
`timescale 1ns/1ns
`default_nettype none
module spi_channel_tb_top;
  import spi_channel_pkg::*;
  logic        clk_i, rst_i, wr, rd, lead, go, sclk, p_sclk, d_sclk, oe_n, ss_n, sdi, sdo, irq;
  logic [15:0] addr, wdata, rdata, q;
  logic [7:0]  ptx, prx;
  int          n_errors, checks, irqs;
  assign sclk = oe_n ? p_sclk : d_sclk;
  spi_channel spi_channel_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .timer_clk_i(1'b0), .serial_clock_pin_i(sclk), .serial_clock_pin_o(d_sclk),
    .serial_clock_pin_oe_n_o(oe_n), .slave_select_n_i(ss_n), .serial_data_in_i(sdi),
    .serial_data_out_o(sdo), .irq_o(irq));
  spi_peer spi_peer_inst (.clk_i(clk_i), .rst_i(rst_i), .lead_i(lead), .go_i(go), .tx_i(ptx), .sclk_i(sclk),
    .sdo_i(sdo), .sclk_o(p_sclk), .ss_n_o(ss_n), .sdi_o(sdi), .rx_o(prx));
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (irq === 1'b1) irqs++;
  task chk(input logic [15:0] s, e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wr_reg(input logic [15:0] a, d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [15:0] a);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(posedge clk_i);
    q = rdata;
  endtask
  task wait_st(input logic [15:0] m, v);
    for (int i = 0; i < 400; i++)
    begin
      rd_reg(OFS_STATUS);
      if ((q & m) === v) return;
    end
    chk(q & m, v);
    end_sim;
  endtask
  task go_peer(input logic [7:0] b);
    @(posedge clk_i);
    ptx <= b;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task t_reset;
    rd_reg(OFS_STATUS);
    chk(q, 16'h0001);
    rd_reg(OFS_CONTROL);
    chk(q, 16'h0000);
    rd_reg(16'h4328);
    chk(q, 16'h0000);
    wr_reg(OFS_CONTROL, 16'hfffe);
    rd_reg(OFS_CONTROL);
    chk(q, 16'h033e);
    wr_reg(OFS_CONTROL, 16'h0000);
  endtask
  task t_master(input logic lsb);
    logic [15:0] c;
    c = lsb ? 16'h0103 : 16'h0033;
    irqs = 0;
    wr_reg(OFS_CONTROL, c);
    go_peer(8'h3c);
    wr_reg(OFS_TX_BYTE, 16'h00a5);
    wait_st(16'h0005, 16'h0005);
    wr_reg(OFS_TX_BYTE, 16'h004b);
    rd_reg(OFS_STATUS);
    chk(q & 16'h0001, 16'h0000);
    // Busy drops for one cycle between frames while tx empty is still low, so the first poll already waits
    wait_st(16'h0007, 16'h0003);
    wait_st(16'h0007, 16'h0003);
    chk({8'h00, prx}, lsb ? 16'h00d2 : 16'h004b);
    rd_reg(OFS_RX_BYTE);
    chk(q, 16'h00a5);
    rd_reg(OFS_STATUS);
    chk(q, 16'h0001);
    chk(16'(irqs), lsb ? 16'h0000 : 16'h0004);
    wr_reg(OFS_CONTROL, c & 16'hfffe);
  endtask
  task t_slave;
    lead <= 1'b1;
    wr_reg(OFS_CONTROL, 16'h0030);
    wr_reg(OFS_CONTROL, 16'h0031);
    irqs = 0;
    wr_reg(OFS_TX_BYTE, 16'h0069);
    rd_reg(OFS_STATUS);
    chk(q, 16'h0000);
    go_peer(8'h96);
    wait_st(16'h0004, 16'h0004);
    wait_st(16'h0006, 16'h0002);
    chk({8'h00, prx}, 16'h0069);
    rd_reg(OFS_RX_BYTE);
    chk(q, 16'h0096);
    chk(16'(irqs), 16'h0002);
  endtask
  initial
  begin
    rst_i = 1'b1;
    {wr, rd, lead, go} = 4'h0;
    {addr, wdata, ptx} = 40'h0;
    n_errors = 0;
    checks = 0;
    irqs = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_master(1'b0);
    t_master(1'b1);
    t_slave;
    end_sim;
  end
endmodule
`default_nettype wire
